// ### rtl/ftc_map.vh
// Register offsets, field positions, reset values and timing counts of the failure control core.
`ifndef FTC_MAP_VH
`define FTC_MAP_VH
`define FTC_OFS_CFG      8'h00
`define FTC_OFS_STAT     8'h04
`define FTC_CFG_DET_BIT  0
`define FTC_CFG_TXTO_BIT 1
`define FTC_CFG_RST      2'h3
`define FTC_ST_FAULT_LSB 0
`define FTC_ST_MODE_LSB  3
`define FTC_ST_WAKE_BIT  6
`define FTC_ST_PO_BIT    7
`define FTC_ST_TXOFF_BIT 8
`define FTC_ST_OPEN_BIT  9
`define FTC_CYC_H1       64
`define FTC_CYC_H2       256
`define FTC_CYC_L6       64
`define FTC_CYC_D47      64
`define FTC_CYC_REC      128
`define FTC_CYC_TXD      20000
`define FTC_CYC_WAKE     20
`define FTC_CYC_BWAKE    40
`define FTC_CYC_SLEEP    100
`endif

// ### rtl/ftc_qual.v
// Persistence qualifier: reports a condition that has held for N consecutive cycles.
module ftc_qual #(
	parameter W = 16,
	parameter N = 16
) (
	input  wire clk,
	input  wire rst,
	input  wire cond,
	output wire hit
);
	localparam [31:0]  LAST_FULL = N - 1;
	localparam [W-1:0] LAST      = LAST_FULL[W-1:0];
	reg [W-1:0] cnt_q;

	// The count restarts whenever the condition drops, so only unbroken runs qualify.
	always @(posedge clk)
	begin
		if (rst || !cond)
			cnt_q <= {W{1'b0}};
		else if (cnt_q != LAST)
			cnt_q <= cnt_q + 1'b1;
	end

	assign hit = cond && (cnt_q == LAST);
endmodule // ftc_qual

// ### rtl/ftc_core.v
// Failure detector, mode control, wake-up and dominant time-out core with an APB register slave.
//
// Function
// R1 - Flag output low: bus failure in normal, wake-up in low power, power-on in po standby.
// R2 - Operating mode is chosen jointly by the standby-select and enable pins.
// R3 - Local wake pin is active low; both its edges count as wake-up events.
// R4 - Any wake-up event switches the regulator control output on; the code leaves it off for a local wake that falls in the cycle entering sleep.
// R5 - Transmit request held low beyond the time-out disables the bus drivers.
// R6 - The dominant time-out timer clears whenever the transmit request is high.
// R7 - Normal mode without failure presents the differential receiver on the receive output.
// R8 - Open wires, CANH to ground, CANL to supply keep drivers, terminations, differential receive.
// R9 - Continuous CANH overvoltage switches to single-wire CANH reception after a first time-out.
// R10 - Persisting CANH overvoltage moves to CANL only, CANH driver off, high termination weak.
// R11 - Qualified CANL overvoltage receives on CANH, CANL driver off, low termination weak.
// R12 - CANH and CANL overvoltage failures recover after a qualified recessive period.
// R13 - CANL to ground or lines shorted: dominant first, then CANL off, weak, single-wire.
// R14 - Those failures recover to differential after differential recessive for a qualified period.
// R15 - Flag goes low on any detected wiring failure and high again on recovery.
// R16 - Open wire is flagged only when seen between transmitter and receiver; flag may toggle.
// R17 - CANH to battery: high termination weak, CANH driver off, receive on CANL.
// R18 - Lines shorted: low termination weak, CANL driver off, receive on CANH.
// R19 - Detector runs fully in normal mode and selects the matching configuration.
// R20 - Pins 11 normal, 10 po standby, 01 go-to-sleep, 00 standby or sleep.
// R21 - Entering normal mode clears the pending wake-up and the power-on flag; a wake event in that same cycle leaves the wake-up pending.
// R22 - All detection, recovery and time-out delays are parameterised cycle counts.
// R23 - Comparator inputs are synchronised before any time-out counter sees them.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`include "ftc_map.vh"
module ftc_core #(
	parameter W       = 16,
	parameter N_H1    = `FTC_CYC_H1, // R22
	parameter N_H2    = `FTC_CYC_H2,
	parameter N_L6    = `FTC_CYC_L6,
	parameter N_D47   = `FTC_CYC_D47,
	parameter N_REC   = `FTC_CYC_REC,
	parameter N_TXD   = `FTC_CYC_TXD,
	parameter N_WAKE  = `FTC_CYC_WAKE,
	parameter N_BWAKE = `FTC_CYC_BWAKE,
	parameter N_SLEEP = `FTC_CYC_SLEEP
) (
	input  wire        CLK,
	input  wire        RST,
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [7:0]  PADDR,
	input  wire [31:0] PWDATA,
	output reg  [31:0] PRDATA,
	output reg         PREADY,
	output reg         PSLVERR,
	input  wire        DRIVE_REQUEST_IN,
	input  wire        LOW_POWER_SELECT_N,
	input  wire        ENABLE_IN,
	input  wire        LOCAL_ROUSE_N,
	input  wire        CANH_HIGH_CMP,
	input  wire        CANL_HIGH_CMP,
	input  wire        DIFF_DOM_CMP,
	input  wire        CANH_DOM_CMP,
	input  wire        CANL_DOM_CMP,
	output reg         BUS_LEVEL_OUT,
	output reg         FAULT_WAKE_FLAG_N,
	output reg         REGULATOR_ON_OUT,
	output reg         HIGH_LINE_TERMINATION,
	output reg         LOW_LINE_TERMINATION,
	output reg         CANH_DRIVE_OUT,
	output reg         CANL_DRIVE_OUT
);
	// Fault states of the detector.
	localparam [2:0] F_NONE = 3'h0;
	localparam [2:0] F_H1   = 3'h1;
	localparam [2:0] F_H2   = 3'h2;
	localparam [2:0] F_L6   = 3'h3;
	localparam [2:0] F_L47  = 3'h4;
	// Operating modes.
	localparam [2:0] M_NORM  = 3'h0;
	localparam [2:0] M_POSTB = 3'h1;
	localparam [2:0] M_GOTO  = 3'h2;
	localparam [2:0] M_STB   = 3'h3;
	localparam [2:0] M_SLEEP = 3'h4;

	reg  [8:0] sy1_q;
	reg  [8:0] sy2_q;
	wire       txd_s;
	wire       stb_s;
	wire       en_s;
	wire       wake_s;
	wire       canh_hi;
	wire       canl_hi;
	wire       diff_dom;
	wire       canh_dom;
	wire       canl_dom;
	reg  [2:0] fault_q;
	reg  [2:0] fault_d;
	reg  [2:0] mode_q;
	reg  [2:0] mode_d;
	reg  [1:0] cfg_q;
	reg        wake_q;
	reg        po_q;
	reg        tx_off_q;
	reg        open_q;
	reg        wake_stab_q;
	wire       det_on;
	wire       drive_dom;
	wire       wake_evt;
	wire       enter_norm;
	wire       h1_hit;
	wire       h2_hit;
	wire       hrec_hit;
	wire       l6_hit;
	wire       lrec_hit;
	wire       d47_hit;
	wire       drec_hit;
	wire       txd_hit;
	wire       lwk_hit;
	wire       bwk_hit;
	wire       slp_hit;
	wire       apb_wr;
	reg  [31:0] rd_d;

	// Every control and comparator pin passes two flip-flops; reset loads idle levels so no false wake edge follows reset.
	always @(posedge CLK)
	begin
		if (RST)
		begin
			sy1_q <= 9'h00B;
			sy2_q <= 9'h00B;
		end
		else
		begin
			sy1_q <= {CANL_DOM_CMP, CANH_DOM_CMP, DIFF_DOM_CMP, CANL_HIGH_CMP, CANH_HIGH_CMP, // R23
				LOCAL_ROUSE_N, ENABLE_IN, LOW_POWER_SELECT_N, DRIVE_REQUEST_IN};
			sy2_q <= sy1_q;
		end
	end

	assign txd_s    = sy2_q[0];
	assign stb_s    = sy2_q[1];
	assign en_s     = sy2_q[2];
	assign wake_s   = sy2_q[3];
	assign canh_hi  = sy2_q[4];
	assign canl_hi  = sy2_q[5];
	assign diff_dom = sy2_q[6];
	assign canh_dom = sy2_q[7];
	assign canl_dom = sy2_q[8];

	// Detector counters run only in normal mode with detection enabled.
	assign det_on = (mode_q == M_NORM) && cfg_q[`FTC_CFG_DET_BIT]; // R19

	// Qualified conditions for failure entry, escalation and recovery.
	ftc_qual #(.W(W), .N(N_H1)) u_h1 (.clk(CLK), .rst(RST), .cond(det_on && canh_hi && fault_q == F_NONE),
		.hit(h1_hit)); // R9
	ftc_qual #(.W(W), .N(N_H2)) u_h2 (.clk(CLK), .rst(RST), .cond(det_on && canh_hi && fault_q == F_H1),
		.hit(h2_hit)); // R10
	ftc_qual #(.W(W), .N(N_REC)) u_hr (.clk(CLK), .rst(RST),
		.cond(det_on && !canh_hi && (fault_q == F_H1 || fault_q == F_H2)), .hit(hrec_hit)); // R12
	ftc_qual #(.W(W), .N(N_L6)) u_l6 (.clk(CLK), .rst(RST), .cond(det_on && canl_hi && fault_q == F_NONE),
		.hit(l6_hit)); // R11
	ftc_qual #(.W(W), .N(N_REC)) u_lr (.clk(CLK), .rst(RST), .cond(det_on && !canl_hi && fault_q == F_L6),
		.hit(lrec_hit)); // R12
	ftc_qual #(.W(W), .N(N_D47)) u_d4 (.clk(CLK), .rst(RST),
		.cond(det_on && diff_dom && !canh_hi && !canl_hi && fault_q == F_NONE), .hit(d47_hit)); // R13
	ftc_qual #(.W(W), .N(N_REC)) u_dr (.clk(CLK), .rst(RST), .cond(det_on && !diff_dom && fault_q == F_L47),
		.hit(drec_hit)); // R14

	// A stuck-low transmit request is timed; any high level restarts the timer.
	ftc_qual #(.W(W), .N(N_TXD)) u_tx (.clk(CLK), .rst(RST), .cond(!txd_s && cfg_q[`FTC_CFG_TXTO_BIT]),
		.hit(txd_hit)); // R6

	// Local wake needs the new level to hold before it counts, which filters glitches on an open pin.
	ftc_qual #(.W(W), .N(N_WAKE)) u_lw (.clk(CLK), .rst(RST), .cond(wake_s != wake_stab_q),
		.hit(lwk_hit)); // R3
	ftc_qual #(.W(W), .N(N_BWAKE)) u_bw (.clk(CLK), .rst(RST),
		.cond(mode_q != M_NORM && (canh_dom || canl_dom)), .hit(bwk_hit));
	ftc_qual #(.W(W), .N(N_SLEEP)) u_sl (.clk(CLK), .rst(RST), .cond(mode_q == M_GOTO),
		.hit(slp_hit));

	assign wake_evt   = (lwk_hit || bwk_hit) && mode_q != M_NORM; // R3
	assign enter_norm = (mode_d == M_NORM) && (mode_q != M_NORM);
	assign drive_dom  = (mode_q == M_NORM) && !txd_s && !tx_off_q;

	// Failure detector state machine; failures 1, 2, 5 and 6a need no change and stay in F_NONE.
	always @*
	begin
		fault_d = fault_q; // R8
		case (fault_q)
			F_NONE:
			begin
				if (h1_hit)
					fault_d = F_H1; // R9
				else if (l6_hit)
					fault_d = F_L6; // R11
				else if (d47_hit)
					fault_d = F_L47; // R13
			end
			F_H1:
			begin
				if (h2_hit)
					fault_d = F_H2; // R10
				else if (hrec_hit)
					fault_d = F_NONE; // R12
			end
			F_H2:
			begin
				if (hrec_hit)
					fault_d = F_NONE; // R12
			end
			F_L6:
			begin
				if (lrec_hit)
					fault_d = F_NONE; // R12
			end
			F_L47:
			begin
				if (drec_hit)
					fault_d = F_NONE; // R14
			end
			default:
				fault_d = F_NONE;
		endcase
	end

	// Mode decode from the two control pins; sleep needs the go-to-sleep command to hold.
	always @*
	begin
		mode_d = mode_q;
		case ({stb_s, en_s})
			2'b11:
				mode_d = M_NORM; // R20
			2'b10:
				mode_d = M_POSTB; // R20
			2'b01:
			begin
				if (mode_q == M_SLEEP)
					mode_d = M_SLEEP;
				else if (slp_hit)
					mode_d = M_SLEEP;
				else
					mode_d = M_GOTO; // R2
			end
			default:
			begin
				if (mode_q == M_GOTO && slp_hit)
					mode_d = M_SLEEP;
				else if (mode_q != M_SLEEP)
					mode_d = M_STB; // R20
			end
		endcase
		if (mode_q == M_SLEEP && wake_evt)
			mode_d = M_STB; // R4
	end

	// State and flags; a wake event beats the clear on entering normal mode.
	always @(posedge CLK)
	begin
		if (RST)
		begin
			fault_q     <= F_NONE;
			mode_q      <= M_POSTB;
			wake_q      <= 1'b0;
			po_q        <= 1'b1;
			tx_off_q    <= 1'b0;
			open_q      <= 1'b0;
			wake_stab_q <= 1'b1;
		end
		else
		begin
			fault_q <= det_on ? fault_d : fault_q; // R19
			mode_q  <= mode_d;
			if (wake_evt)
				wake_q <= 1'b1;
			else if (enter_norm)
				wake_q <= 1'b0; // R21
			if (enter_norm)
				po_q <= 1'b0; // R21
			if (txd_s)
				tx_off_q <= 1'b0; // R6
			else if (txd_hit)
				tx_off_q <= 1'b1; // R5
			if (lwk_hit)
				wake_stab_q <= wake_s; // R3
			// An open wire only shows while this node drives and the receivers disagree.
			if (!det_on || fault_q != F_NONE)
				open_q <= 1'b0;
			else if (drive_dom)
				open_q <= canh_dom ^ canl_dom; // R16
		end
	end

	// Output stage: pin levels chosen per mode and failure, all registered.
	always @(posedge CLK)
	begin
		if (RST)
		begin
			BUS_LEVEL_OUT         <= 1'b1;
			FAULT_WAKE_FLAG_N     <= 1'b1;
			REGULATOR_ON_OUT      <= 1'b1;
			HIGH_LINE_TERMINATION <= 1'b1;
			LOW_LINE_TERMINATION  <= 1'b1;
			CANH_DRIVE_OUT        <= 1'b0;
			CANL_DRIVE_OUT        <= 1'b0;
		end
		else
		begin
			REGULATOR_ON_OUT      <= (mode_d != M_SLEEP); // R4
			HIGH_LINE_TERMINATION <= (fault_q != F_H2); // R17
			LOW_LINE_TERMINATION  <= (fault_q != F_L6) && (fault_q != F_L47); // R18
			CANH_DRIVE_OUT        <= drive_dom && (fault_q != F_H2); // R10
			CANL_DRIVE_OUT        <= drive_dom && (fault_q != F_L6) && (fault_q != F_L47); // R13
			if (mode_q != M_NORM)
				BUS_LEVEL_OUT <= !wake_q;
			else if (fault_q == F_H1 || fault_q == F_L6 || fault_q == F_L47)
				BUS_LEVEL_OUT <= !canh_dom; // R13
			else if (fault_q == F_H2)
				BUS_LEVEL_OUT <= !canl_dom; // R17
			else
				BUS_LEVEL_OUT <= !diff_dom; // R7
			if (mode_q == M_NORM)
				FAULT_WAKE_FLAG_N <= !((fault_q != F_NONE) || open_q); // R15
			else if (mode_q == M_POSTB)
				FAULT_WAKE_FLAG_N <= !po_q; // R1
			else
				FAULT_WAKE_FLAG_N <= !wake_q; // R1
		end
	end

	// Read mux for the two words; anything else is an unmapped address.
	always @*
	begin
		rd_d = 32'h00000000;
		if (PADDR == `FTC_OFS_CFG)
			rd_d[1:0] = cfg_q;
		else if (PADDR == `FTC_OFS_STAT)
		begin
			rd_d[`FTC_ST_FAULT_LSB+2:`FTC_ST_FAULT_LSB] = fault_q;
			rd_d[`FTC_ST_MODE_LSB+2:`FTC_ST_MODE_LSB]   = mode_q;
			rd_d[`FTC_ST_WAKE_BIT]  = wake_q;
			rd_d[`FTC_ST_PO_BIT]    = po_q;
			rd_d[`FTC_ST_TXOFF_BIT] = tx_off_q;
			rd_d[`FTC_ST_OPEN_BIT]  = open_q;
		end
	end

	assign apb_wr = PSEL && PENABLE && PREADY && PWRITE;

	// APB slave: one wait-free access phase, answer prepared in the setup cycle.
	always @(posedge CLK)
	begin
		if (RST)
		begin
			cfg_q   <= `FTC_CFG_RST;
			PREADY  <= 1'b0;
			PRDATA  <= 32'h00000000;
			PSLVERR <= 1'b0;
		end
		else
		begin
			PREADY <= PSEL && !PENABLE;
			if (PSEL && !PENABLE)
			begin
				PRDATA  <= PWRITE ? 32'h00000000 : rd_d;
				PSLVERR <= (PADDR != `FTC_OFS_CFG) && (PADDR != `FTC_OFS_STAT);
			end
			if (apb_wr && PADDR == `FTC_OFS_CFG)
				cfg_q <= PWDATA[1:0];
		end
	end
endmodule // ftc_core

// ### verif/ftc_ctl_model.sv
// Controller model that drives the mode pins and the transmit request.
module ftc_ctl_model (
	input  wire       clk,
	input  wire [1:0] mode_sel,
	input  wire       tx_dom,
	output reg        lp_sel_n = 1'b1,
	output reg        en = 1'b0,
	output reg        txd = 1'b1
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pins start in power-on standby with the bus recessive, set once at their declaration.
	// Pins move just after an edge, like a port register, so the syncs never see a glitch.
	always @(posedge clk)
	begin
		lp_sel_n <= mode_sel[1];
		en <= mode_sel[0];
		txd <= !tx_dom;
	end
endmodule // ftc_ctl_model

// ### verif/ftc_core_properties.sv
// Port-level assertions for the failure control core.
module ftc_props #(
	parameter N_TXD = 20000
) (
	input wire CLK,
	input wire RST,
	input wire PSEL,
	input wire PENABLE,
	input wire PREADY,
	input wire DRIVE_REQUEST_IN,
	input wire LOCAL_ROUSE_N,
	input wire BUS_LEVEL_OUT,
	input wire FAULT_WAKE_FLAG_N,
	input wire REGULATOR_ON_OUT,
	input wire HIGH_LINE_TERMINATION,
	input wire LOW_LINE_TERMINATION,
	input wire CANH_DRIVE_OUT,
	input wire CANL_DRIVE_OUT
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	reg [15:0] lo_q;
	// Counts raw low request cycles; it saturates so a stuck pin never wraps back.
	always @(posedge CLK)
	begin
		if (RST || DRIVE_REQUEST_IN)
			lo_q <= 16'h0000;
		else if (lo_q != 16'hFFFF)
			lo_q <= lo_q + 16'h0001;
	end
	rst_vals_a: assert property (disable iff (1'b0) RST |=> BUS_LEVEL_OUT && FAULT_WAKE_FLAG_N
		&& REGULATOR_ON_OUT && HIGH_LINE_TERMINATION && LOW_LINE_TERMINATION && !CANH_DRIVE_OUT
		&& !CANL_DRIVE_OUT && !PREADY) else $error("outputs not at reset values");
	apb_ready_a: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready after setup");
	ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready too long");
	txd_cut_a: assert property (lo_q > N_TXD + 6 |-> !CANH_DRIVE_OUT && !CANL_DRIVE_OUT)
		else $error("drivers on after time-out");
	txd_idle_a: assert property (DRIVE_REQUEST_IN [*5] |=> !CANH_DRIVE_OUT && !CANL_DRIVE_OUT)
		else $error("drivers on while idle");
	hterm_drv_a: assert property (!HIGH_LINE_TERMINATION |-> !CANH_DRIVE_OUT)
		else $error("high driver on with weak termination");
	lterm_drv_a: assert property (!LOW_LINE_TERMINATION |-> !CANL_DRIVE_OUT)
		else $error("low driver on with weak termination");
	wake_reg_a: assert property ($changed(LOCAL_ROUSE_N) ##1 $stable(LOCAL_ROUSE_N) [*8]
		|-> ##[0:8] REGULATOR_ON_OUT) else $error("regulator off after wake");
endmodule // ftc_props
bind ftc_core ftc_props #(.N_TXD(N_TXD)) u_props (.*);

// ### verif/tb_top.sv
// Self-checking bench for the failure control core.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam N_H1 = 4, N_H2 = 10, N_L6 = 4, N_D47 = 10, N_REC = 6, N_TXD = 20;
	localparam N_WAKE = 4, N_BWAKE = 5, N_SLEEP = 6;
	reg         CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	reg  [7:0]  PADDR = 8'h00;
	reg  [31:0] PWDATA = 32'h0, rd_q;
	reg         LOCAL_ROUSE_N = 1'b1, CANH_HIGH_CMP = 1'b0, CANL_HIGH_CMP = 1'b0;
	reg         DIFF_DOM_CMP = 1'b0, CANH_DOM_CMP = 1'b0, CANL_DOM_CMP = 1'b0, tx_dom = 1'b0;
	reg  [1:0]  mode_sel = 2'b10;
	wire [31:0] PRDATA;
	wire        PREADY, PSLVERR, DRIVE_REQUEST_IN, LOW_POWER_SELECT_N, ENABLE_IN, BUS_LEVEL_OUT;
	wire        FAULT_WAKE_FLAG_N, REGULATOR_ON_OUT, HIGH_LINE_TERMINATION, LOW_LINE_TERMINATION;
	wire        CANH_DRIVE_OUT, CANL_DRIVE_OUT;
	integer     bad_count = 0, cmp_count = 0, seed, i, fc;
	ftc_ctl_model u_ctl (.clk(CLK), .mode_sel(mode_sel), .tx_dom(tx_dom), .lp_sel_n(LOW_POWER_SELECT_N),
		.en(ENABLE_IN), .txd(DRIVE_REQUEST_IN));
	// Short delays keep the run brief; the design takes them as cycle counts.
	ftc_core #(.N_H1(N_H1), .N_H2(N_H2), .N_L6(N_L6), .N_D47(N_D47), .N_REC(N_REC), .N_TXD(N_TXD),
		.N_WAKE(N_WAKE), .N_BWAKE(N_BWAKE), .N_SLEEP(N_SLEEP)) u_dut (.*);
	always #25 CLK = !CLK;
	// Counts every comparison and reports a mismatch at once.
	task chk(input [31:0] seen, input [31:0] exp, input [47:0] nm);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp)
			begin
				bad_count = bad_count + 1;
				$display("ERROR %0s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task cyc(input integer n); repeat (n) @(posedge CLK); endtask
	// One APB transfer; the request is held until PREADY is sampled high.
	task apb(input w, input [7:0] a, input [31:0] d, input [31:0] exp, input err);
		begin
			@(posedge CLK);
			PSEL <= 1'b1;
			PWRITE <= w;
			PADDR <= a;
			PWDATA <= d;
			@(posedge CLK);
			PENABLE <= 1'b1;
			@(posedge CLK);
			while (PREADY !== 1'b1) @(posedge CLK);
			rd_q = PRDATA;
			chk(PSLVERR, err, "slverr");
			if (!w) chk(rd_q, exp, "prdata");
			PSEL <= 1'b0;
			PENABLE <= 1'b0;
		end
	endtask
	// Receive path of the model: differential, CANL only, or CANH only.
	function [31:0] rx(input integer f);
		rx = (f == 0) ? !DIFF_DOM_CMP : (f == 2) ? !CANL_DOM_CMP : !CANH_DOM_CMP;
	endfunction
	task finish_test;
		begin
			$display("CHECKS %0d MISMATCHES %0d", cmp_count, bad_count);
			if (bad_count == 0 && cmp_count > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	// The whole run needs under a thousand cycles, so this limit only trips on a hang.
	initial
	begin
		#2000000;
		bad_count = bad_count + 1;
		finish_test;
	end
	// Main sequence: registers, normal mode, time-out, failures, low power and wake.
	initial
	begin
		seed = 32'h2BE404E1;
		cyc(2);
		RST <= 1'b0;
		cyc(6);
		chk(FAULT_WAKE_FLAG_N, 0, "flag");
		apb(0, 8'h04, 0, 32'h88, 0);
		apb(0, 8'h00, 0, 32'h3, 0);
		apb(1, 8'h04, 32'hFFFFFFFF, 0, 0);
		apb(0, 8'h08, 0, 0, 1);
		fc = $random(seed);
		apb(1, 8'h00, fc, 0, 0);
		apb(0, 8'h00, 0, fc & 3, 0);
		apb(1, 8'h00, 3, 0, 0);
		$display("TEST registers done");
		mode_sel <= 2'b11;
		cyc(8);
		chk(FAULT_WAKE_FLAG_N, 1, "flag");
		apb(0, 8'h04, 0, 0, 0);
		for (i = 0; i < 2; i = i + 1)
		begin
			DIFF_DOM_CMP <= !i[0];
			cyc(5);
			chk(BUS_LEVEL_OUT, rx(0), "rxd");
		end
		tx_dom <= 1'b1;
		cyc(6);
		chk({CANH_DRIVE_OUT, CANL_DRIVE_OUT}, 3, "drive");
		cyc(N_TXD + 4);
		chk({CANH_DRIVE_OUT, CANL_DRIVE_OUT}, 0, "drive");
		apb(0, 8'h04, 0, 32'h100, 0);
		tx_dom <= 1'b0;
		cyc(4);
		tx_dom <= 1'b1;
		cyc(6);
		chk({CANH_DRIVE_OUT, CANL_DRIVE_OUT}, 3, "drive");
		CANH_DOM_CMP <= 1'b1;
		cyc(3);
		apb(0, 8'h04, 0, 32'h200, 0);
		tx_dom <= 1'b0;
		CANH_DOM_CMP <= 1'b0;
		cyc(6);
		apb(0, 8'h04, 0, 0, 0);
		$display("TEST normal done");
		for (i = 0; i < 3; i = i + 1)
		begin
			{CANH_HIGH_CMP, CANL_HIGH_CMP, DIFF_DOM_CMP} <= 3'b100 >> i;
			fc = i + 2;
			cyc(5);
			if (i == 2) chk(BUS_LEVEL_OUT, 0, "rxd");
			if (i == 0) apb(0, 8'h04, 0, 1, 0);
			cyc(18);
			apb(0, 8'h04, 0, fc, 0);
			chk(FAULT_WAKE_FLAG_N, 0, "flag");
			chk({HIGH_LINE_TERMINATION, LOW_LINE_TERMINATION}, (i == 0) ? 1 : 2, "term");
			tx_dom <= 1'b1;
			// CANL only mode must follow the CANL receiver, the others the CANH receiver.
			{CANH_DOM_CMP, CANL_DOM_CMP} <= (i == 0) ? 2'b01 : 2'b10;
			cyc(6);
			chk({CANH_DRIVE_OUT, CANL_DRIVE_OUT}, (i == 0) ? 1 : 2, "drive");
			chk(BUS_LEVEL_OUT, rx(fc), "rxd");
			tx_dom <= 1'b0;
			{CANH_HIGH_CMP, CANL_HIGH_CMP, DIFF_DOM_CMP, CANH_DOM_CMP, CANL_DOM_CMP} <= 5'h00;
			cyc(14);
			apb(0, 8'h04, 0, 0, 0);
			chk(FAULT_WAKE_FLAG_N, 1, "flag");
		end
		$display("TEST failures done");
		for (i = 0; i < 3; i = i + 1)
		begin
			mode_sel <= 2'b01;
			cyc(12);
			mode_sel <= 2'b00;
			cyc(6);
			chk(REGULATOR_ON_OUT, 0, "inh");
			apb(0, 8'h04, 0, 32'h20, 0);
			if (i < 2) LOCAL_ROUSE_N <= i[0];
			else CANH_DOM_CMP <= 1'b1;
			cyc(14);
			chk(REGULATOR_ON_OUT, 1, "inh");
			chk(FAULT_WAKE_FLAG_N, 0, "flag");
			apb(0, 8'h04, 0, 32'h58, 0);
			CANH_DOM_CMP <= 1'b0;
			mode_sel <= 2'b11;
			cyc(8);
			chk(FAULT_WAKE_FLAG_N, 1, "flag");
			apb(0, 8'h04, 0, 0, 0);
		end
		$display("TEST wake done");
		finish_test;
	end
endmodule // tb_top
